/* File: logic/hw_return_stack.sv */
`timescale 1ns/1ns
`default_nettype none
module hw_return_stack
    import stack_boot_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = STACK_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire stack_req_s       req,
    output logic [WIDTH-1:0]      rd_data,
    output logic [3:0]            stack_pointer
);

    logic [WIDTH-1:0] entries [DEPTH];
    logic             is_push;
    logic             is_pop;

    assign is_push = (req.op == OP_PUSH) || (req.op == OP_CALL)
                   || (req.op == OP_VECTOR);
    assign is_pop  = (req.op == OP_POP) || (req.op == OP_RET)
                   || (req.op == OP_INTERRUPT_RETURN) || (req.op == OP_PULL);

    // Pointer wraps silently in both directions.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stack_pointer <= SP_RESET;
        end else if (is_push) begin
            stack_pointer <= 4'(stack_pointer + 4'h1);
        end else if (is_pop) begin
            stack_pointer <= 4'(stack_pointer - 4'h1);
        end
    end

    // Write goes to the slot the incremented pointer selects.
    always_ff @(posedge clk) begin
        if (is_push) begin
            entries[4'(stack_pointer + 4'h1)] <= req.data;
        end
    end

    // Read the slot under the pointer before it moves down.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= '0;
        end else if (is_pop) begin
            rd_data <= entries[stack_pointer];
        end
    end

    AST_SP_RESET: assert property (
        @(posedge clk)
        $rose(nrst) |-> stack_pointer == SP_RESET)
        else $error("Pointer not at top after reset.");

    AST_PUSH_INC: assert property (
        @(posedge clk) disable iff (!nrst)
        is_push |=> stack_pointer == 4'($past(stack_pointer) + 4'h1))
        else $error("Push did not increment pointer.");

    AST_POP_DEC: assert property (
        @(posedge clk) disable iff (!nrst)
        is_pop |=> stack_pointer == 4'($past(stack_pointer) - 4'h1))
        else $error("Pop did not decrement pointer.");

    AST_PUSH_POP: assert property (
        @(posedge clk) disable iff (!nrst)
        (is_push ##1 is_pop) |=> rd_data == $past(req.data, 2))
        else $error("Popped value differs from pushed value.");

endmodule : hw_return_stack
`default_nettype wire

/* File: logic/stack_boot_password_lock.sv */
// How it works
// - Sixteen-entry, sixteen-bit hardware stack for returns and data.
// - Calls, returns, interrupt returns and vectoring use the stack.
// - Reset puts the stack pointer at entry fifteen.
// - Push-type operations increment the pointer, then write.
// - Pop-type operations read the pointer's entry, then decrement.
// - By default code and data addresses decode separately.
// - Alternate mode maps code, data and ROM into one map.
// - Four-kilobyte utility ROM decoded at base 8000h by default.
// - After any reset the program counter starts inside the ROM.
// - ROM start-up branches to address zero or a service routine.
// - Program words 0010h to 001Fh form the password.
// - Lock set at power-on; blocks access unless blank or password given.
// - Lock clear permits debug and programming without a password.
// - Mass erase leaves all password words at all ones.
// - Request bit set at boot_done makes the ROM run the loader when utility access is permitted.
// - Loader may clear the request and reset into the application.
// - Loader offers load, verify, dump, erase and checksum.
`timescale 1ns/1ns
`default_nettype none
module stack_boot_password_lock
    import stack_boot_pkg::*;
#(
    parameter logic [15:0] ROM_BASE = ROM_BASE_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        por_event,
    input  wire stack_req_s  stack_req,
    output logic [15:0]      stack_rd_data,
    output logic [3:0]       stack_pointer,
    input  wire logic        unified_map,
    input  wire mem_req_s    mem_req,
    output mem_sel_s         mem_sel,
    output logic [15:0]      reset_pc,
    input  wire logic        boot_done,
    input  wire logic        boot_to_loader,
    output logic [15:0]      boot_target,
    input  wire logic        pw_word_valid,
    input  wire logic [3:0]  pw_word_index,
    input  wire logic [15:0] pw_word_data,
    input  wire logic        pw_supply_valid,
    input  wire logic [3:0]  pw_supply_index,
    input  wire logic [15:0] pw_supply_data,
    input  wire logic        mass_erase_done,
    input  wire logic        lock_write,
    input  wire logic        lock_value,
    output logic             code_read_lock,
    output logic             utility_access_ok,
    input  wire logic        jtag_sysprog_instr,
    input  wire logic        jtag_set_request,
    input  wire logic        loader_clear,
    output logic             loader_entry_request,
    output logic             run_loader,
    input  wire logic        loader_op_valid,
    input  wire loader_op_e  loader_op,
    output logic             loader_op_accept,
    output loader_op_e       loader_op_active
);

    ////////////////////////////////////////////////////////////////////////
    // Hardware stack.

    hw_return_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (STACK_WIDTH)
    ) u_stack (
        .clk           (clk),
        .nrst          (nrst),
        .req           (stack_req),
        .rd_data       (stack_rd_data),
        .stack_pointer (stack_pointer)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    function automatic logic in_rom(input logic [15:0] a);
        logic [16:0] top;
        top = {1'b0, ROM_BASE} + {1'b0, ROM_SIZE_BYTES};
        return ({1'b0, a} >= {1'b0, ROM_BASE}) && ({1'b0, a} < top);
    endfunction : in_rom

    mem_sel_s next_mem_sel;

    always_comb begin
        next_mem_sel = '0;
        next_mem_sel.offset = mem_req.addr;
        if (in_rom(mem_req.addr) && (unified_map || mem_req.is_fetch)) begin
            next_mem_sel.rom_sel = 1'b1;
            next_mem_sel.offset  = 16'(mem_req.addr - ROM_BASE);
        end else if (unified_map) begin
            // One contiguous map: upper half is data, lower half code.
            next_mem_sel.data_sel = mem_req.addr[15];
            next_mem_sel.code_sel = !mem_req.addr[15];
        end else begin
            next_mem_sel.code_sel = mem_req.is_fetch;
            next_mem_sel.data_sel = !mem_req.is_fetch;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_sel <= '0;
        end else begin
            mem_sel <= next_mem_sel;
        end
    end

    AST_ROM_WINDOW: assert property (
        @(posedge clk) disable iff (!nrst)
        (16'(mem_req.addr - ROM_BASE) < ROM_SIZE_BYTES && mem_req.is_fetch)
            |=> mem_sel.rom_sel
            && mem_sel.offset == 16'($past(mem_req.addr) - ROM_BASE))
        else $error("Fetch inside the utility window missed the ROM.");

    AST_MAP_SPLIT: assert property (
        @(posedge clk) disable iff (!nrst)
        !unified_map |=>
            mem_sel.data_sel != $past(mem_req.is_fetch))
        else $error("Split map sent an access to the wrong space.");

    AST_ONE_SELECT: assert property (
        @(posedge clk) disable iff (!nrst)
        nrst |=> $onehot({mem_sel.code_sel, mem_sel.data_sel,
                          mem_sel.rom_sel}))
        else $error("Access did not select exactly one memory.");

    ////////////////////////////////////////////////////////////////////////
    // Reset vector and start-up branch.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reset_pc    <= ROM_BASE;
            boot_target <= APP_START;
        end else begin
            reset_pc <= ROM_BASE;
            if (boot_done) begin
                boot_target <= boot_to_loader ? ROM_BASE
                                              : APP_START;
            end
        end
    end

    AST_PC_IN_ROM: assert property (
        @(posedge clk) disable iff (!nrst)
        16'(reset_pc - ROM_BASE) < ROM_SIZE_BYTES)
        else $error("Start address lies outside the utility ROM.");

    AST_BOOT_APP: assert property (
        @(posedge clk) disable iff (!nrst)
        (boot_done && !boot_to_loader) |=> boot_target == APP_START)
        else $error("Plain start did not branch to the application.");

    ////////////////////////////////////////////////////////////////////////
    // Password words and lock.

    logic [PW_WORDS-1:0] word_ones;
    logic [PW_WORDS-1:0] word_zeros;
    logic [PW_WORDS-1:0] word_match;
    logic [15:0]         pw_store [PW_WORDS];
    logic                pw_blank;
    logic                pw_given;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_ones  <= '1;
            word_zeros <= '0;
        end else if (mass_erase_done) begin
            word_ones  <= '1;
            word_zeros <= '0;
        end else if (pw_word_valid) begin
            word_ones[pw_word_index]  <=
                (pw_word_data == PW_ALL_ONES);
            word_zeros[pw_word_index] <= (pw_word_data == PW_ALL_ZEROS);
        end
    end

    always_ff @(posedge clk) begin
        if (mass_erase_done) begin
            for (int i = 0; i < PW_WORDS; i++) begin
                pw_store[i] <= PW_ALL_ONES;
            end
        end else if (pw_word_valid) begin
            pw_store[pw_word_index] <= pw_word_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_match <= '0;
        end else if (pw_word_valid || mass_erase_done) begin
            word_match <= '0;
        end else if (pw_supply_valid) begin
            word_match[pw_supply_index] <=
                (pw_store[pw_supply_index] == pw_supply_data);
        end
    end

    assign pw_blank = (&word_ones) || (&word_zeros);
    assign pw_given = &word_match;

    // Lock is set by every reset and by a power-on event; a write loads lock_value into it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_read_lock <= LOCK_RESET;
        end else if (por_event) begin
            code_read_lock <= LOCK_RESET;
        end else if (lock_write) begin
            code_read_lock <= lock_value;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            utility_access_ok <= 1'b0;
        end else begin
            utility_access_ok <= !code_read_lock || pw_blank
                                 || pw_given;
        end
    end

    AST_LOCK_BLOCKS: assert property (
        @(posedge clk) disable iff (!nrst)
        (code_read_lock && !pw_blank && !pw_given) |=> !utility_access_ok)
        else $error("Utility access granted while locked.");

    AST_UNLOCK_OPEN: assert property (
        @(posedge clk) disable iff (!nrst)
        !code_read_lock |=> utility_access_ok)
        else $error("Access refused with lock clear.");

    AST_ERASE_BLANK: assert property (
        @(posedge clk) disable iff (!nrst)
        mass_erase_done |=> pw_blank ##1 utility_access_ok)
        else $error("Password not blank after mass erase.");

    AST_LOCK_POR: assert property (
        @(posedge clk) disable iff (!nrst)
        por_event |=> code_read_lock)
        else $error("Power-on event did not set the lock.");

    ////////////////////////////////////////////////////////////////////////
    // Loader entry request.

    logic [1:0] jtag_sync [3];
    logic       request_seen;

    // Host pins belong to the test clock, so they pass three stages.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            jtag_sync[0] <= '0;
            jtag_sync[1] <= '0;
            jtag_sync[2] <= '0;
        end else begin
            jtag_sync[0] <= {jtag_sysprog_instr, jtag_set_request};
            jtag_sync[1] <= jtag_sync[0];
            jtag_sync[2] <= jtag_sync[1];
        end
    end

    // A change counts only once the last two stages agree on it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            request_seen <= LOADER_RESET;
        end else if (jtag_sync[1] == jtag_sync[2]) begin
            request_seen <= &jtag_sync[2];
        end
    end

    AST_SYNC_HOLD: assert property (
        @(posedge clk) disable iff (!nrst)
        (jtag_sync[1] != jtag_sync[2]) |=> $stable(request_seen))
        else $error("Request changed before two stages agreed.");

    // Set wins over a clear arriving in the same cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loader_entry_request <= LOADER_RESET;
        end else if (request_seen) begin
            loader_entry_request <= 1'b1;
        end else if (loader_clear) begin
            loader_entry_request <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_loader <= 1'b0;
        end else if (boot_done) begin
            run_loader <= loader_entry_request
                          && utility_access_ok;
        end else if (loader_clear) begin
            run_loader <= 1'b0;
        end
    end

    assign loader_op_accept = run_loader && loader_op_valid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loader_op_active <= LD_LOAD;
        end else if (loader_op_accept) begin
            loader_op_active <= loader_op;
        end
    end

    AST_OP_REFUSED: assert property (
        @(posedge clk) disable iff (!nrst)
        !run_loader |-> !loader_op_accept)
        else $error("Loader operation accepted while loader idle.");

    AST_OP_TAKEN: assert property (
        @(posedge clk) disable iff (!nrst)
        loader_op_accept |=> loader_op_active == $past(loader_op))
        else $error("Accepted loader operation not recorded.");

    AST_CLEAR_STOPS: assert property (
        @(posedge clk) disable iff (!nrst)
        (loader_clear && !request_seen && !boot_done) |=> !run_loader
            ##0 !loader_entry_request)
        else $error("Loader still active after clear.");

    AST_SET_WINS: assert property (
        @(posedge clk) disable iff (!nrst)
        request_seen |=> loader_entry_request)
        else $error("Loader request lost.");

endmodule : stack_boot_password_lock
`default_nettype wire

/* File: logic/stack_boot_pkg.sv */
package stack_boot_pkg;

    localparam int          STACK_DEPTH      = 16;
    localparam int          STACK_WIDTH      = 16;
    localparam logic [3:0]  SP_RESET         = 4'hF;
    localparam logic [15:0] ROM_BASE_DEFAULT = 16'h8000;
    localparam logic [15:0] ROM_SIZE_BYTES   = 16'h1000;
    localparam logic [15:0] APP_START        = 16'h0000;
    localparam logic [15:0] PW_FIRST         = 16'h0010;
    localparam logic [15:0] PW_LAST          = 16'h001F;
    localparam int          PW_WORDS         = 16;
    localparam logic [15:0] PW_ALL_ONES      = 16'hFFFF;
    localparam logic [15:0] PW_ALL_ZEROS     = 16'h0000;
    localparam logic        LOCK_RESET       = 1'b1;
    localparam logic        LOADER_RESET     = 1'b0;

    typedef enum logic [2:0] {
        OP_NONE   = 3'b000,
        OP_PUSH   = 3'b001,
        OP_CALL   = 3'b010,
        OP_VECTOR = 3'b011,
        OP_POP    = 3'b100,
        OP_RET    = 3'b101,
        OP_INTERRUPT_RETURN   = 3'b110,
        OP_PULL   = 3'b111
    } stack_op_e;

    typedef enum logic [2:0] {
        LD_LOAD   = 3'b000,
        LD_VERIFY = 3'b001,
        LD_DUMP   = 3'b010,
        LD_ERASE  = 3'b011,
        LD_CRC    = 3'b100
    } loader_op_e;

    typedef struct packed {
        stack_op_e   op;
        logic [15:0] data;
    } stack_req_s;

    typedef struct packed {
        logic [15:0] addr;
        logic        is_fetch;
    } mem_req_s;

    typedef struct packed {
        logic code_sel;
        logic data_sel;
        logic rom_sel;
        logic [15:0] offset;
    } mem_sel_s;

endpackage : stack_boot_pkg

/* File: testbench/jtag_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module jtag_host_model (
    input  wire logic clk,
    input  wire logic enter,
    output logic      sysprog_instr,
    output logic      set_request
);
    initial begin
        sysprog_instr = 1'b0;
        set_request   = 1'b0;
    end
    // The instruction is loaded first and the request bit a cycle later.
    always @(posedge clk) begin
        sysprog_instr <= #1 enter;
        set_request   <= #1 enter & sysprog_instr;
    end
endmodule : jtag_host_model
`default_nettype wire

/* File: testbench/tb_stack_boot_password_lock.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_stack_boot_password_lock;
    import stack_boot_pkg::*;
    logic        clk, nrst, por_event, unified_map, boot_done;
    logic        boot_to_loader, pw_word_valid, pw_supply_valid;
    logic        mass_erase_done, lock_write, lock_value, code_read_lock;
    logic        utility_access_ok, host_enter, jtag_sysprog_instr;
    logic        jtag_set_request, loader_clear, loader_entry_request;
    logic        run_loader, loader_op_valid, loader_op_accept;
    logic [3:0]  stack_pointer, pw_word_index, pw_supply_index;
    logic [15:0] stack_rd_data, reset_pc, boot_target;
    logic [15:0] pw_word_data, pw_supply_data;
    stack_req_s  stack_req;
    mem_req_s    mem_req;
    mem_sel_s    mem_sel;
    loader_op_e  loader_op, loader_op_active;
    int          miscompares;
    int          cmp_count;

    stack_boot_password_lock stack_boot_password_lock_i (
        .clk, .nrst, .por_event, .stack_req, .stack_rd_data,
        .stack_pointer, .unified_map, .mem_req, .mem_sel, .reset_pc,
        .boot_done, .boot_to_loader, .boot_target, .pw_word_valid,
        .pw_word_index, .pw_word_data, .pw_supply_valid, .pw_supply_index,
        .pw_supply_data, .mass_erase_done, .lock_write, .lock_value,
        .code_read_lock, .utility_access_ok, .jtag_sysprog_instr,
        .jtag_set_request, .loader_clear, .loader_entry_request,
        .run_loader, .loader_op_valid, .loader_op, .loader_op_accept,
        .loader_op_active
    );
    jtag_host_model jtag_host_model_i (
        .clk(clk), .enter(host_enter), .sysprog_instr(jtag_sysprog_instr),
        .set_request(jtag_set_request)
    );

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d mismatches", cmp_count,
                 miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////
    task automatic test_stack();
        stack_op_e pu[4] = '{OP_PUSH, OP_CALL, OP_VECTOR, OP_PUSH};
        stack_op_e po[4] = '{OP_PULL, OP_INTERRUPT_RETURN, OP_RET, OP_POP};
        check(16'(stack_pointer), 16'h000F, "reset pointer");
        for (int i = 0; i < 4; i++) begin
            stack_req.op = pu[i];
            stack_req.data = 16'hC000 + 16'(i);
            tick(1);
            check(16'(stack_pointer), 16'(i), "push pointer");
        end
        for (int i = 0; i < 4; i++) begin
            stack_req.op = po[i];
            tick(1);
            check(stack_rd_data, 16'hC003 - 16'(i), "pop data");
            check(16'(stack_pointer), 16'((2 - i) & 15), "pop ptr");
        end
        stack_req.op = OP_NONE;
        $display("Done: stack test");
    endtask : test_stack

    task automatic mem_case(input logic um, input logic [15:0] a,
                            input logic f, input logic [2:0] exp);
        unified_map = um;
        mem_req.addr = a;
        mem_req.is_fetch = f;
        tick(1);
        check({13'h0, mem_sel.code_sel, mem_sel.data_sel, mem_sel.rom_sel},
              {13'h0, exp}, "select");
        if (exp[0])
            check(mem_sel.offset, a - ROM_BASE_DEFAULT, "offset");
    endtask : mem_case

    task automatic test_map();
        mem_case(1'b0, 16'h8004, 1'b1, 3'b001);
        mem_case(1'b0, 16'h8004, 1'b0, 3'b010);
        mem_case(1'b0, 16'h0100, 1'b1, 3'b100);
        mem_case(1'b1, 16'h8FFF, 1'b0, 3'b001);
        mem_case(1'b1, 16'h9000, 1'b0, 3'b010);
        mem_case(1'b1, 16'h0100, 1'b0, 3'b100);
        $display("Done: map test");
    endtask : test_map

    ////////////////////////////////////////////////////////////////////
    task automatic pw_store(input logic [15:0] base, input logic inc);
        pw_word_valid = 1'b1;
        for (int i = 0; i < 16; i++) begin
            pw_word_index = 4'(i);
            pw_word_data = base + (inc ? 16'(i) : 16'h0000);
            tick(1);
        end
        pw_word_valid = 1'b0;
        tick(4);
    endtask : pw_store

    task automatic pw_give(input int bad);
        pw_supply_valid = 1'b1;
        for (int i = 0; i < 16; i++) begin
            pw_supply_index = 4'(i);
            pw_supply_data = 16'h1230 + 16'(i) ^ 16'(i == bad);
            tick(1);
        end
        pw_supply_valid = 1'b0;
        tick(4);
    endtask : pw_give

    task automatic test_lock();
        pw_store(16'h1230, 1'b1);
        check(16'(utility_access_ok), 16'h0000, "locked");
        pulse(mass_erase_done);
        tick(4);
        check(16'(utility_access_ok), 16'h0001, "erased");
        pw_store(16'h1230, 1'b1);
        pw_give(3);
        check(16'(utility_access_ok), 16'h0000, "bad word");
        pw_give(16);
        check(16'(utility_access_ok), 16'h0001, "given");
        pw_store(16'h1230, 1'b1);
        check(16'(utility_access_ok), 16'h0000, "rewritten");
        pw_store(16'h0000, 1'b0);
        check(16'(utility_access_ok), 16'h0001, "zeros");
        pw_store(16'h1230, 1'b1);
        lock_value = 1'b0;
        pulse(lock_write);
        tick(4);
        check(16'(code_read_lock), 16'h0000, "cleared");
        check(16'(utility_access_ok), 16'h0001, "open");
        pulse(por_event);
        tick(4);
        check(16'(code_read_lock), 16'h0001, "power on");
        check(16'(utility_access_ok), 16'h0000, "relocked");
        pulse(lock_write);
        tick(4);
        $display("Done: lock test");
    endtask : test_lock

    task automatic test_loader();
        loader_op_valid = 1'b1;
        #1;
        check(16'(loader_op_accept), 16'h0000, "refused");
        loader_op_valid = 1'b0;
        host_enter = 1'b1;
        tick(8);
        check(16'(loader_entry_request), 16'h0001, "request");
        host_enter = 1'b0;
        tick(3);
        boot_to_loader = 1'b1;
        pulse(boot_done);
        tick(2);
        check(16'(run_loader), 16'h0001, "loader runs");
        check(boot_target, ROM_BASE_DEFAULT, "loader target");
        loader_op_valid = 1'b1;
        for (int k = 0; k < 5; k++) begin
            loader_op = loader_op_e'(k);
            #1;
            check(16'(loader_op_accept), 16'h0001, "accept");
            tick(1);
            check(16'(loader_op_active), 16'(k), "active op");
        end
        loader_op_valid = 1'b0;
        pulse(loader_clear);
        tick(3);
        check(16'(loader_entry_request), 16'h0000, "clear");
        nrst = 1'b0;
        tick(2);
        check(reset_pc, ROM_BASE_DEFAULT, "reset pc");
        check(16'(stack_pointer), 16'h000F, "reset sp");
        nrst = 1'b1;
        boot_to_loader = 1'b0;
        tick(2);
        pulse(boot_done);
        tick(2);
        check(16'(run_loader), 16'h0000, "no loader");
        check(boot_target, APP_START, "app start");
        $display("Done: loader test");
    endtask : test_loader

    ////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, por_event, unified_map, boot_done, boot_to_loader} = '0;
        {pw_word_valid, pw_supply_valid, mass_erase_done} = '0;
        {lock_write, lock_value, host_enter, loader_clear} = '0;
        {loader_op_valid, pw_word_index, pw_supply_index} = '0;
        {pw_word_data, pw_supply_data, mem_req} = '0;
        stack_req = '{op: OP_NONE, data: 16'h0000};
        loader_op = LD_LOAD;
        miscompares = 0;
        cmp_count = 0;
        tick(20);
        nrst = 1'b1;
        tick(1);
        test_stack();
        test_map();
        test_lock();
        test_loader();
        tally_and_finish();
    end

    initial begin
        #100000;
        miscompares++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : tb_stack_boot_password_lock
`default_nettype wire
